/* File: rtl/eps_pkg.sv */
package eps_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_TIMER_SELECT  = 4'h0;
  localparam logic [3:0] ADDR_SHUTDOWN_CTRL = 4'h1;
  localparam logic [3:0] ADDR_RESTART_DELAY = 4'h2;
  localparam logic [3:0] ADDR_STEERING      = 4'h3;
  localparam logic [3:0] ADDR_UNIT_CONTROL  = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS    = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK      = 4'h6;

  localparam logic [7:0] RST_TIMER_SELECT  = 8'h00;
  localparam logic [7:0] RST_SHUTDOWN_CTRL = 8'h00;
  localparam logic [7:0] RST_RESTART_DELAY = 8'h00;
  localparam logic [7:0] RST_STEERING      = 8'h01;
  localparam logic [7:0] RST_UNIT_CONTROL  = 8'h00;
  localparam logic [7:0] STEER_MASK        = 8'h1F;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FLAG_BIT      = 7;
  localparam int SRC_HI        = 6;
  localparam int SRC_LO        = 4;
  localparam int AC_HI         = 3;
  localparam int AC_LO         = 2;
  localparam int BD_HI         = 1;
  localparam int BD_LO         = 0;
  localparam int RESTART_BIT   = 7;
  localparam int DELAY_HI      = 6;
  localparam int SYNC_BIT      = 4;
  localparam int MODE_HI       = 3;
  localparam int MODE_LO       = 2;
  localparam int POL_BD_BIT    = 0;
  localparam int POL_AC_BIT    = 1;
  localparam int OCFG_HI       = 7;
  localparam int OCFG_LO       = 6;
  localparam int SEL_W         = 2;
  localparam int NUM_UNITS     = 4;
  localparam int NUM_TIMERS    = 3;
  localparam int NUM_PINS      = 4;

  localparam logic [1:0] MODE_PWM    = 2'h3;
  localparam logic [1:0] OCFG_SINGLE = 2'h0;
  localparam logic [1:0] SS_HIGH     = 2'h1;
  localparam logic [6:0] DELAY_ZERO  = 7'h00;

  // irq status bits
  localparam int IRQ_SHUTDOWN = 0;
  localparam int IRQ_RESTART  = 1;

  // shutdown source codes
  localparam logic [2:0] SRC_OFF     = 3'h0;
  localparam logic [2:0] SRC_C1      = 3'h1;
  localparam logic [2:0] SRC_C2      = 3'h2;
  localparam logic [2:0] SRC_C1_C2   = 3'h3;
  localparam logic [2:0] SRC_FLT     = 3'h4;
  localparam logic [2:0] SRC_FLT_C1  = 3'h5;
  localparam logic [2:0] SRC_FLT_C2  = 3'h6;
  localparam logic [2:0] SRC_FLT_ALL = 3'h7;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } eps_bus_req_type;

  typedef struct packed {
    logic [NUM_PINS-1:0] value;
    logic [NUM_PINS-1:0] drive;
  } eps_pins_type;

endpackage : eps_pkg

/* File: rtl/eps_pwm_steer.sv */
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
// How it works
// [R1] each unit's timebase chosen by 2-bit code
// [R2] timer select fields 7-6..1-0, reset zero
// [R3] flag bit 7 set holds shutdown output state
// [R4] source codes 000-011: off, comparators
// [R5] codes 100-111 add low fault pin
// [R6] shutdown state of pins a and c
// [R7] shutdown state of pins b and d
// [R8] synced comparator delays shutdown by timer1
// [R9] auto restart clears flag once cause gone
// [R10] without auto restart software clears flag
// [R11] active edge delayed by 7-bit count
// [R12] delay field cleared on clock-safety reset
// [R13] steering updates at period or instruction
// [R14] steer bits route waveform with polarity
// [R15] steering only in pwm single-output mode
// [R16] low mode bits set pair polarities
// [R17] resume output only at next period start
// [R18] flag stays set while source active
module eps_pwm_steer (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire eps_pkg::eps_bus_req_type bus,
  output logic [7:0]                rdata,
  output logic                      irq,
  input  wire logic [2:0]           timer_period_start,
  input  wire logic [2:0]           timer_pwm_level,
  output logic [3:0]                unit_period_start,
  output logic [3:0]                unit_pwm_level,
  input  wire logic                 comparator1_out,
  input  wire logic                 comparator2_out,
  input  wire logic                 comparator1_sync_en,
  input  wire logic                 comparator2_sync_en,
  input  wire logic                 timer1_sync_tick,
  input  wire logic                 fault_input_pin,
  input  wire logic                 clock_safety_reset,
  input  wire logic [3:0]           port_value,
  input  wire logic [3:0]           port_drive,
  output eps_pkg::eps_pins_type     pins
);
  import eps_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] pwm_timer_select;
  logic [7:0] auto_shutdown_control;
  logic [7:0] restart_and_delay_control;
  logic [7:0] output_steering_control;
  logic [7:0] unit_control;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [4:0] steer_active;
  logic       shutdown_event_flag;
  logic       hold_off;
  logic       c1_synced;
  logic       c2_synced;
  logic       src_active;
  logic       sw_clear;
  logic       next_flag;
  logic       steer_ok;
  logic [6:0] delay_cnt;
  logic       delayed_level;
  logic       pwm_raw;
  logic       period_start;

  wire [2:0] shutdown_source_select  = auto_shutdown_control[SRC_HI:SRC_LO];
  wire [1:0] pair_ac_shutdown_state  = auto_shutdown_control[AC_HI:AC_LO];
  wire [1:0] pair_bd_shutdown_state  = auto_shutdown_control[BD_HI:BD_LO];
  wire       auto_restart_enable     = restart_and_delay_control[RESTART_BIT];
  wire [6:0] active_edge_delay_count = restart_and_delay_control[DELAY_HI:0];
  wire       steering_update_sync    = output_steering_control[SYNC_BIT];
  wire [3:0] unit_mode_field         = unit_control[MODE_HI:0];
  wire [1:0] output_configuration_field = unit_control[OCFG_HI:OCFG_LO];

  // ---------------------------------------------------------------
  // timer selection per unit
  // ---------------------------------------------------------------
  genvar u;
  generate
    for (u = 0; u < NUM_UNITS; u++) begin : g_unit
      logic [1:0] choice;
      assign choice = pwm_timer_select[u*SEL_W +: SEL_W];
      // reserved code 11 gives no timebase
      assign unit_period_start[u] = (choice < 2'(NUM_TIMERS)) ?
                                    timer_period_start[choice] : 1'b0; // [R1]
      assign unit_pwm_level[u]    = (choice < 2'(NUM_TIMERS)) ?
                                    timer_pwm_level[choice] : 1'b0; // [R1]
    end
  endgenerate

  // unit 0 drives the enhanced pins
  assign period_start = unit_period_start[0];
  assign pwm_raw      = unit_pwm_level[0];

  // ---------------------------------------------------------------
  // shutdown sources
  // ---------------------------------------------------------------
  // synced comparators only update on timer1 ticks
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      c1_synced <= 1'b0;
      c2_synced <= 1'b0;
    end else if (timer1_sync_tick) begin
      c1_synced <= comparator1_out;
      c2_synced <= comparator2_out;
    end
  end

  logic c1_eff;
  logic c2_eff;
  logic flt_eff;
  assign c1_eff  = comparator1_sync_en ? c1_synced : comparator1_out; // [R8]
  assign c2_eff  = comparator2_sync_en ? c2_synced : comparator2_out; // [R8]
  assign flt_eff = !fault_input_pin;

  always_comb begin
    case (shutdown_source_select)
      SRC_OFF:     src_active = 1'b0; // [R4]
      SRC_C1:      src_active = c1_eff; // [R4]
      SRC_C2:      src_active = c2_eff; // [R4]
      SRC_C1_C2:   src_active = c1_eff | c2_eff; // [R4]
      SRC_FLT:     src_active = flt_eff; // [R5]
      SRC_FLT_C1:  src_active = flt_eff | c1_eff; // [R5]
      SRC_FLT_C2:  src_active = flt_eff | c2_eff; // [R5]
      SRC_FLT_ALL: src_active = flt_eff | c1_eff | c2_eff; // [R5]
      default:     src_active = 1'b0;
    endcase
  end

  assign sw_clear = bus.wr && (bus.addr == ADDR_SHUTDOWN_CTRL) &&
                    !bus.wdata[FLAG_BIT];

  // ---------------------------------------------------------------
  // shutdown flag
  // ---------------------------------------------------------------
  always_comb begin
    next_flag = shutdown_event_flag;
    if (shutdown_event_flag && !src_active) begin
      if (auto_restart_enable)
        next_flag = 1'b0; // [R9]
      else if (sw_clear)
        next_flag = 1'b0; // [R10]
    end
    // a live source wins over any clear
    if (src_active)
      next_flag = 1'b1; // [R3] [R18]
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      shutdown_event_flag <= 1'b0;
    else
      shutdown_event_flag <= next_flag;
  end

  // outputs stay parked until the next period begins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      hold_off <= 1'b0;
    else if (next_flag)
      hold_off <= 1'b1;
    else if (period_start)
      hold_off <= 1'b0; // [R17]
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwm_timer_select      <= RST_TIMER_SELECT; // [R2]
      auto_shutdown_control <= RST_SHUTDOWN_CTRL;
      output_steering_control <= RST_STEERING;
      unit_control          <= RST_UNIT_CONTROL;
      irq_mask              <= 2'h0;
    end else if (bus.wr) begin
      case (bus.addr)
        ADDR_TIMER_SELECT:  pwm_timer_select <= bus.wdata; // [R2]
        ADDR_SHUTDOWN_CTRL: auto_shutdown_control <= bus.wdata;
        ADDR_STEERING:      output_steering_control <= bus.wdata & STEER_MASK;
        ADDR_UNIT_CONTROL:  unit_control <= bus.wdata;
        ADDR_IRQ_MASK:      irq_mask <= bus.wdata[1:0];
        default: ;
      endcase
    end
  end

  // restart bit stays writable while the delay field is forced
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      restart_and_delay_control <= RST_RESTART_DELAY;
    end else begin
      if (bus.wr && bus.addr == ADDR_RESTART_DELAY)
        restart_and_delay_control <= bus.wdata;
      if (clock_safety_reset)
        restart_and_delay_control[DELAY_HI:0] <= DELAY_ZERO; // [R12]
    end
  end

  // ---------------------------------------------------------------
  // steering
  // ---------------------------------------------------------------
  // sync mode waits for the period start; else next cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      steer_active <= RST_STEERING[4:0];
    else if (!steering_update_sync || period_start)
      steer_active <= output_steering_control[4:0]; // [R13]
  end

  assign steer_ok = (unit_mode_field[MODE_HI:MODE_LO] == MODE_PWM) &&
                    (output_configuration_field == OCFG_SINGLE); // [R15]

  // ---------------------------------------------------------------
  // active edge delay
  // ---------------------------------------------------------------
  // only rising edges are delayed; falls pass at once
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      delay_cnt     <= DELAY_ZERO;
      delayed_level <= 1'b0;
    end else if (!pwm_raw) begin
      delay_cnt     <= DELAY_ZERO;
      delayed_level <= 1'b0;
    end else if (delay_cnt >= active_edge_delay_count) begin
      delayed_level <= 1'b1; // [R11]
    end else begin
      delay_cnt <= delay_cnt + 7'h01; // [R11]
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  logic [NUM_PINS-1:0] next_value;
  logic [NUM_PINS-1:0] next_drive;

  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_pin
      logic [1:0] ss;
      logic       inv;
      logic       steered;
      assign ss  = (p % 2 == 0) ? pair_ac_shutdown_state : pair_bd_shutdown_state;
      assign inv = (p % 2 == 0) ? unit_mode_field[POL_AC_BIT] :
                                  unit_mode_field[POL_BD_BIT]; // [R16]
      assign steered = steer_ok && steer_active[p]; // [R14]
      assign next_value[p] = !steered ? port_value[p] :
                             hold_off ? (ss == SS_HIGH) : // [R6] [R7]
                             (delayed_level ^ inv); // [R14] [R16]
      assign next_drive[p] = !steered ? port_drive[p] :
                             hold_off ? !ss[1] : 1'b1; // [R6] [R7]
    end
  endgenerate

  // one register for the whole pin word keeps a single driver
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pins <= '0;
    end else begin
      pins.value <= next_value;
      pins.drive <= next_drive;
    end
  end

  // ---------------------------------------------------------------
  // interrupts and read back
  // ---------------------------------------------------------------
  wire rd_status = bus.rd && (bus.addr == ADDR_IRQ_STATUS);
  wire ev_shut   = next_flag && !shutdown_event_flag;
  wire ev_rest   = !next_flag && shutdown_event_flag;

  // a new event beats the read clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      irq_status <= 2'h0;
    else
      irq_status <= (rd_status ? 2'h0 : irq_status) | {ev_rest, ev_shut};
  end

  assign irq = |(irq_status & irq_mask);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      rdata <= 8'h00;
    else if (bus.rd) begin
      case (bus.addr)
        ADDR_TIMER_SELECT:  rdata <= pwm_timer_select;
        ADDR_SHUTDOWN_CTRL: rdata <= {shutdown_event_flag, auto_shutdown_control[6:0]};
        ADDR_RESTART_DELAY: rdata <= restart_and_delay_control;
        ADDR_STEERING:      rdata <= output_steering_control;
        ADDR_UNIT_CONTROL:  rdata <= unit_control;
        ADDR_IRQ_STATUS:    rdata <= {6'h00, irq_status};
        ADDR_IRQ_MASK:      rdata <= {6'h00, irq_mask};
        default:            rdata <= 8'h00;
      endcase
    end else
      rdata <= 8'h00;
  end

endmodule : eps_pwm_steer

/* File: bench/eps_fault_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// comparator and fault pin source
// ---------------------------------------------------------------
module eps_fault_model (
  input  wire logic [2:0] cause,
  output logic            comparator1_out,
  output logic            comparator2_out,
  output logic            fault_input_pin
);
  assign comparator1_out = cause[0];
  assign comparator2_out = cause[1];
  // open-drain fault line, pulled up when released
  assign fault_input_pin = !cause[2];
endmodule : eps_fault_model

/* File: bench/eps_pwm_steer_checker.sv */
`timescale 1ns/1ps
module eps_pwm_steer_checker (
  input wire logic                     clk,
  input wire logic                     nrst,
  input wire eps_pkg::eps_bus_req_type bus,
  input wire logic [7:0]               rdata,
  input wire logic                     irq,
  input wire logic [2:0]               timer_period_start,
  input wire logic [2:0]               timer_pwm_level,
  input wire logic [3:0]               unit_period_start,
  input wire logic [3:0]               unit_pwm_level,
  input wire logic                     comparator1_out,
  input wire logic                     comparator2_out,
  input wire logic                     comparator1_sync_en,
  input wire logic                     comparator2_sync_en,
  input wire logic                     fault_input_pin,
  input wire logic                     clock_safety_reset,
  input wire eps_pkg::eps_pins_type    pins
);
  import eps_pkg::*;
  logic [7:0] tsel, ctrl, mask;
  logic [7:0] steer, ucfg;
  logic       steer_set;
  logic [2:0] act_cnt;
  logic [3:0] exp_lvl, exp_ps;
  logic       src_on;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tsel <= RST_TIMER_SELECT;
      ctrl <= RST_SHUTDOWN_CTRL;
      mask <= 8'h00;
      steer <= RST_STEERING;
      ucfg <= RST_UNIT_CONTROL;
    end else if (bus.wr) begin
      if (bus.addr == ADDR_STEERING) steer <= bus.wdata & STEER_MASK;
      if (bus.addr == ADDR_UNIT_CONTROL) ucfg <= bus.wdata;
      if (bus.addr == ADDR_TIMER_SELECT) tsel <= bus.wdata;
      if (bus.addr == ADDR_SHUTDOWN_CTRL) ctrl <= bus.wdata;
      if (bus.addr == ADDR_IRQ_MASK) mask <= bus.wdata;
    end
  end
  // synced comparators left out: their timing depends on the tick
  assign src_on = (ctrl[4] & comparator1_out & !comparator1_sync_en)
                | (ctrl[5] & comparator2_out & !comparator2_sync_en)
                | (ctrl[6] & !fault_input_pin);
  // parking only shows on pins steered in pwm single mode, immediate update
  assign steer_set = ucfg[3:2] == 2'h3 && ucfg[7:6] == 2'h0 && !steer[4];
  // any write restarts the count so pin settings have settled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) act_cnt <= 3'h0;
    else if (!src_on || bus.wr) act_cnt <= 3'h0;
    else if (act_cnt != 3'h7) act_cnt <= act_cnt + 3'h1;
  end
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      exp_lvl[k] = (tsel[2*k+:2] == 2'h3) ? 1'b0 : timer_pwm_level[tsel[2*k+:2]];
      exp_ps[k] = (tsel[2*k+:2] == 2'h3) ? 1'b0 : timer_period_start[tsel[2*k+:2]];
    end
  end
  sequence rd_ctrl;
    bus.rd && bus.addr == ADDR_SHUTDOWN_CTRL;
  endsequence
  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  a_unit_select: assert property (unit_pwm_level == exp_lvl && unit_period_start == exp_ps)
    else $error("unit timebase wrong");
  a_delay_forced: assert property ($past(clock_safety_reset) && clock_safety_reset
    && bus.rd && bus.addr == ADDR_RESTART_DELAY |=> rdata[6:0] == 7'h00)
    else $error("delay field not forced");
  a_steer_upper: assert property (bus.rd && bus.addr == ADDR_STEERING |=> rdata[7:5] == 3'h0)
    else $error("steering upper bits set");
  a_flag_held: assert property (act_cnt >= 3'h4 ##0 rd_ctrl |=> rdata[7])
    else $error("shutdown flag not set");
  a_park_ac: assert property (act_cnt >= 3'h4 && steer_set |->
    (!steer[0] || (pins.drive[0] == !ctrl[3] && (ctrl[3] || pins.value[0] == ctrl[2])))
    && (!steer[2] || (pins.drive[2] == !ctrl[3] && (ctrl[3] || pins.value[2] == ctrl[2]))))
    else $error("pins a c not parked");
  a_park_bd: assert property (act_cnt >= 3'h4 && steer_set |->
    (!steer[1] || (pins.drive[1] == !ctrl[1] && (ctrl[1] || pins.value[1] == ctrl[0])))
    && (!steer[3] || (pins.drive[3] == !ctrl[1] && (ctrl[1] || pins.value[3] == ctrl[0]))))
    else $error("pins b d not parked");
  a_irq_masked: assert property (mask[1:0] == 2'h0 |-> !irq)
    else $error("masked interrupt raised");
endmodule : eps_pwm_steer_checker
bind eps_pwm_steer eps_pwm_steer_checker u_chk (.clk, .nrst, .bus, .rdata, .irq,
  .timer_period_start, .timer_pwm_level, .unit_period_start, .unit_pwm_level,
  .comparator1_out, .comparator2_out, .comparator1_sync_en, .comparator2_sync_en,
  .fault_input_pin, .clock_safety_reset, .pins);

/* File: bench/eps_pwm_steer_test.sv */
`timescale 1ns/1ps
module eps_pwm_steer_test;
  import eps_pkg::*;
  logic            clk, nrst, irq, c1s, c2s, tick, csr, c1, c2, flt;
  logic [2:0]      cause, tps, tlvl;
  logic [3:0]      ups, ulvl, pv, pd;
  logic [7:0]      rdata, v, c;
  eps_bus_req_type bus;
  eps_pins_type    pins;
  int              n_mismatch, n_compared;
  eps_pwm_steer dut (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata), .irq(irq),
    .timer_period_start(tps), .timer_pwm_level(tlvl), .unit_period_start(ups),
    .unit_pwm_level(ulvl), .comparator1_out(c1), .comparator2_out(c2),
    .comparator1_sync_en(c1s), .comparator2_sync_en(c2s), .timer1_sync_tick(tick),
    .fault_input_pin(flt), .clock_safety_reset(csr), .port_value(pv), .port_drive(pd),
    .pins(pins));
  eps_fault_model model (.cause(cause), .comparator1_out(c1), .comparator2_out(c2),
    .fault_input_pin(flt));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, rdata);
  endtask : rchk
  task automatic pchk(input logic [3:0] e);
    repeat (3) @(posedge clk);
    #1;
    chk("pins", {4'hF, e}, {pins.drive, pins.value});
  endtask : pchk
  task automatic pstart;
    @(posedge clk);
    tps <= 3'h7;
    @(posedge clk);
    tps <= 3'h0;
  endtask : pstart
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {nrst, c1s, c2s, tick, csr, cause, tps} = '0;
    bus = '0;
    tlvl = 3'h7;
    pv = 4'h5;
    pd = 4'hF;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rchk(ADDR_TIMER_SELECT, RST_TIMER_SELECT);
    rchk(ADDR_SHUTDOWN_CTRL, RST_SHUTDOWN_CTRL);
    rchk(ADDR_RESTART_DELAY, RST_RESTART_DELAY);
    rchk(ADDR_STEERING, RST_STEERING);
    wr(4'h7, 8'hFF);
    rchk(4'h7, 8'h00);
    wr(ADDR_TIMER_SELECT, 8'hE4);
    rchk(ADDR_TIMER_SELECT, 8'hE4);
    tlvl <= 3'h2;
    @(posedge clk);
    #1;
    chk("unit level", 8'h02, {4'h0, ulvl});
    wr(ADDR_TIMER_SELECT, 8'h00);
    tlvl <= 3'h7;
    $display("test registers done");
    wr(ADDR_UNIT_CONTROL, 8'h0C);
    wr(ADDR_STEERING, 8'h0F);
    for (int k = 0; k < 3; k++) begin
      for (int s = 0; s < 8; s++) begin
        c = {1'b0, s[2:0], k[1:0], 2'(2 - k)};
        wr(ADDR_SHUTDOWN_CTRL, c);
        cause <= 3'(1 << k);
        repeat (4) @(posedge clk);
        rchk(ADDR_SHUTDOWN_CTRL, c | {s[k], 7'h00});
        wr(ADDR_SHUTDOWN_CTRL, c);
        rchk(ADDR_SHUTDOWN_CTRL, c | {s[k], 7'h00});
        cause <= 3'h0;
        repeat (3) @(posedge clk);
        rchk(ADDR_SHUTDOWN_CTRL, c | {s[k], 7'h00});
        wr(ADDR_SHUTDOWN_CTRL, c);
        rchk(ADDR_SHUTDOWN_CTRL, c);
      end
    end
    $display("test sources done");
    wr(ADDR_RESTART_DELAY, 8'h80);
    wr(ADDR_IRQ_MASK, 8'h01);
    rchk(ADDR_IRQ_STATUS, 8'h03);
    wr(ADDR_SHUTDOWN_CTRL, 8'h40);
    cause <= 3'h4;
    repeat (4) @(posedge clk);
    chk("irq", 8'h01, {7'h0, irq});
    rchk(ADDR_IRQ_STATUS, 8'h01);
    chk("irq", 8'h00, {7'h0, irq});
    cause <= 3'h0;
    repeat (4) @(posedge clk);
    rchk(ADDR_SHUTDOWN_CTRL, 8'h40);
    rchk(ADDR_IRQ_STATUS, 8'h02);
    pchk(4'h0);
    pstart();
    pchk(4'hF);
    wr(ADDR_STEERING, 8'h01);
    $display("test restart done");
    wr(ADDR_SHUTDOWN_CTRL, 8'h10);
    c1s <= 1'b1;
    cause <= 3'h1;
    repeat (4) @(posedge clk);
    rchk(ADDR_SHUTDOWN_CTRL, 8'h10);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    repeat (3) @(posedge clk);
    rchk(ADDR_SHUTDOWN_CTRL, 8'h90);
    cause <= 3'h0;
    c1s <= 1'b0;
    wr(ADDR_RESTART_DELAY, 8'h80);
    repeat (4) @(posedge clk);
    rchk(ADDR_SHUTDOWN_CTRL, 8'h10);
    csr <= 1'b1;
    wr(ADDR_RESTART_DELAY, 8'h7F);
    rchk(ADDR_RESTART_DELAY, 8'h00);
    csr <= 1'b0;
    wr(ADDR_RESTART_DELAY, 8'h05);
    rchk(ADDR_RESTART_DELAY, 8'h05);
    wr(ADDR_UNIT_CONTROL, 8'h0C);
    tlvl <= 3'h0;
    pstart();
    pchk(4'h4);
    tlvl <= 3'h7;
    pchk(4'h4);
    repeat (3) @(posedge clk);
    pchk(4'h5);
    wr(ADDR_RESTART_DELAY, 8'h00);
    $display("test delay done");
    wr(ADDR_STEERING, 8'h05);
    wr(ADDR_UNIT_CONTROL, 8'h0E);
    pstart();
    pchk(4'h0);
    wr(ADDR_STEERING, 8'h0F);
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_UNIT_CONTROL, {6'h03, p[1:0]});
      pstart();
      pchk({!p[0], !p[1], !p[0], !p[1]});
    end
    wr(ADDR_UNIT_CONTROL, 8'h4F);
    pchk(4'h5);
    wr(ADDR_UNIT_CONTROL, 8'h0B);
    pchk(4'h5);
    wr(ADDR_UNIT_CONTROL, 8'h0F);
    pstart();
    pchk(4'h0);
    wr(ADDR_STEERING, 8'h1A);
    pchk(4'h0);
    pstart();
    pchk(4'h5);
    $display("test steering done");
    final_report();
  end
endmodule : eps_pwm_steer_test
